// *** hw/gpr_save_bank.sv ***
// Machine-check save area for the extended general registers
`timescale 1ns/1ps
`default_nettype none
module gpr_save_bank #(
   parameter int NREG = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic capture_i,
   input wire logic long_mode_i,
   input wire logic [NREG*64-1:0] gpr_i,
   input wire logic [$clog2(NREG)-1:0] rd_idx_i,
   output logic [63:0] rd_data_o,
   output logic valid_o
);
   logic [63:0] save_ff [NREG];
   logic valid_ff;

   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : gen_save
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               save_ff[g] <= 64'h0;
            end else if (capture_i) begin
               save_ff[g] <= gpr_i[g*64 +: 64];
            end
         end
      end
   endgenerate

   // contents valid only from 64-bit mode
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_ff <= 1'b0;
      end else if (capture_i) begin
         valid_ff <= long_mode_i;
      end
   end

   assign rd_data_o = save_ff[rd_idx_i];
   assign valid_o = valid_ff;
endmodule
`default_nettype wire

// *** hw/perf_thermal_msr_bank.sv ***
// Performance-state and thermal management register bank, Avalon-MM slave
//
// Functional notes
// - Current performance state reads as a 16-bit read-only field, upper bits zero.
// - Target performance state is a 16-bit software read/write field, upper bits zero.
// - The clock throttle register holds an on-demand enable and a duty-cycle field.
// - The thermal interrupt control register enables interrupts on temperature transitions.
// - One thermal status register shows sensor status and a sticky hot log.
// - On model 3 a write to the second monitor target sets it and a read returns it.
// - On models 4 and 6 the second monitor target reads back but a write faults.
// - Feature bit 0 enables fast strings and resets to one.
// - Feature bit 2 enables last-opcode compatibility, resets to zero; bit 1 reserved.
// - Feature bit 3 enables sensor-driven clock modulation, resets to zero.
// - Extended register save contents are meaningful only if captured in 64-bit mode.
// - The feature register is read/write and each of bits 0, 2 and 3 controls one function.
//
// Each 64-bit register is seen as two words: low word at the index, high word at
// index with bit 10 of the word address set.
`timescale 1ns/1ps
`default_nettype none
module perf_thermal_msr_bank #(
   parameter logic [3:0] PART_MODEL = 4'h3
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Avalon-MM slave
   input wire logic [13:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   // Core side
   input wire logic [15:0] cur_perf_i,
   input wire logic sensor_hot_i,
   input wire logic mc_capture_i,
   input wire logic long_mode_i,
   input wire logic [511:0] gpr_i,
   output logic [15:0] target_perf_o,
   output logic throttle_en_o,
   output logic [2:0] throttle_duty_o,
   output logic auto_mod_en_o,
   output logic fast_strings_en_o,
   output logic fop_compat_en_o,
   output logic [15:0] mon2_target_o,
   output logic gp_fault_o,
   output logic irq_o
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic hot_s1_ff;
   logic hot_s2_ff;
   logic hot_prev_ff;
   logic [15:0] perf_s1_ff;
   logic [15:0] perf_s2_ff;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hot_s1_ff <= 1'b0;
         hot_s2_ff <= 1'b0;
         hot_prev_ff <= 1'b0;
      end else begin
         hot_s1_ff <= sensor_hot_i;
         hot_s2_ff <= hot_s1_ff;
         hot_prev_ff <= hot_s2_ff;
      end
   end

   // Multi-bit value: consumer tolerates one stale sample during change
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         perf_s1_ff <= 16'h0000;
         perf_s2_ff <= 16'h0000;
      end else begin
         perf_s1_ff <= cur_perf_i;
         perf_s2_ff <= perf_s1_ff;
      end
   end

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ANSWER = 3'b010,
      ST_DONE = 3'b100
   } bus_state_t;

   bus_state_t state_ff;
   logic [9:0] idx;
   logic hi_word;
   logic acc_wr;
   logic [15:0] wmask;
   logic [31:0] nxt_rdata;
   logic nxt_decerr;

   assign idx = avs_address_i[11:2];
   assign hi_word = avs_address_i[12];
   // One write takes effect in ST_ANSWER, the edge where waitrequest is low
   assign acc_wr = avs_write_i && (state_ff == ST_ANSWER);

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : gen_mask
         assign wmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
      end
   endgenerate

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [15:0] tgt_perf_ff;
   logic thr_en_ff;
   logic [2:0] thr_duty_ff;
   logic [1:0] tirq_ff;
   logic hot_log_ff;
   logic [15:0] mon2_ff;
   logic [perf_thermal_pkg::FE_W-1:0] fe_ff;
   logic [perf_thermal_pkg::EVT_W-1:0] evt_ff;
   logic [perf_thermal_pkg::EVT_W-1:0] evt_mask_ff;
   logic gp_fault_ff;
   logic irq_ff;
   logic [perf_thermal_pkg::EVT_W-1:0] evt_set;
   logic mon2_wr;
   logic mon2_fault;
   logic [63:0] save_data;
   logic save_valid;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                         input logic [15:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   // 16-bit target performance state, reserved upper bits dropped
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tgt_perf_ff <= perf_thermal_pkg::TGT_PERF_RESET;
      end else if (acc_wr && !hi_word && idx == perf_thermal_pkg::IDX_TGT_PERF) begin
         tgt_perf_ff <= merge(tgt_perf_ff, avs_writedata_i[15:0], wmask);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         thr_en_ff <= 1'b0;
         thr_duty_ff <= 3'h0;
      end else if (acc_wr && !hi_word && idx == perf_thermal_pkg::IDX_THROTTLE
                   && avs_byteenable_i[0]) begin
         thr_en_ff <= avs_writedata_i[perf_thermal_pkg::THR_EN_BIT];
         thr_duty_ff <= avs_writedata_i[perf_thermal_pkg::THR_DUTY_W:1];
      end
   end

   // interrupt enables for hot and cool transitions
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tirq_ff <= 2'h0;
      end else if (acc_wr && !hi_word && idx == perf_thermal_pkg::IDX_THERM_IRQ
                   && avs_byteenable_i[0]) begin
         tirq_ff <= avs_writedata_i[1:0];
      end
   end

   // sticky hot log, cleared by writing zero; a new hot edge wins
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hot_log_ff <= 1'b0;
      end else if (hot_s2_ff && !hot_prev_ff) begin
         hot_log_ff <= 1'b1;
      end else if (acc_wr && !hi_word && idx == perf_thermal_pkg::IDX_THERM_STATE
                   && avs_byteenable_i[0]
                   && !avs_writedata_i[perf_thermal_pkg::TST_HOT_LOG_BIT]) begin
         hot_log_ff <= 1'b0;
      end
   end

   // model 3 accepts the write; models 4 and 6 fault instead
   assign mon2_wr = acc_wr && !hi_word && idx == perf_thermal_pkg::IDX_MON2_TGT;
   assign mon2_fault = mon2_wr && (PART_MODEL != perf_thermal_pkg::MODEL_WRITES_OK);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mon2_ff <= perf_thermal_pkg::MON2_RESET;
      end else if (mon2_wr && !mon2_fault) begin
         mon2_ff <= merge(mon2_ff, avs_writedata_i[15:0], wmask);
      end
   end

   // feature bits; resets in FE_RESET, bit 1 held zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fe_ff <= perf_thermal_pkg::FE_RESET;
      end else if (acc_wr && !hi_word && idx == perf_thermal_pkg::IDX_FEATURES
                   && avs_byteenable_i[0]) begin
         fe_ff <= avs_writedata_i[3:0] & 4'hD;
      end
   end

   // ----------------------------------------
   // Events and interrupt
   // ----------------------------------------
   // transitions become events only when enabled
   assign evt_set[perf_thermal_pkg::EVT_HOT_BIT] =
      hot_s2_ff && !hot_prev_ff && tirq_ff[perf_thermal_pkg::TIRQ_HI_BIT];
   assign evt_set[perf_thermal_pkg::EVT_COOL_BIT] =
      !hot_s2_ff && hot_prev_ff && tirq_ff[perf_thermal_pkg::TIRQ_LO_BIT];
   assign evt_set[perf_thermal_pkg::EVT_GPF_BIT] = mon2_fault;

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_ff <= '0;
      end else if (acc_wr && !hi_word && idx == perf_thermal_pkg::IDX_EVT_STATUS
                   && avs_byteenable_i[0]) begin
         evt_ff <= (evt_ff & ~avs_writedata_i[perf_thermal_pkg::EVT_W-1:0]) | evt_set;
      end else begin
         evt_ff <= evt_ff | evt_set;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_mask_ff <= '0;
      end else if (acc_wr && !hi_word && idx == perf_thermal_pkg::IDX_EVT_MASK
                   && avs_byteenable_i[0]) begin
         evt_mask_ff <= avs_writedata_i[perf_thermal_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_ff <= 1'b0;
         gp_fault_ff <= 1'b0;
      end else begin
         irq_ff <= |(evt_ff & evt_mask_ff);
         gp_fault_ff <= mon2_fault;
      end
   end

   // ----------------------------------------
   // Machine-check save area
   // ----------------------------------------
   gpr_save_bank #(
      .NREG(8)
   ) u_save (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .capture_i(mc_capture_i),
      .long_mode_i(long_mode_i),
      .gpr_i(gpr_i),
      .rd_idx_i(idx[2:0]),
      .rd_data_o(save_data),
      .valid_o(save_valid)
   );

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   // unlisted and reserved bits read as zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_decerr = 1'b0;
      if (hi_word) begin
         // saved value hidden unless captured in 64-bit mode
         if (idx >= perf_thermal_pkg::IDX_GPR_SAVE_BASE && idx < 10'h198) begin
            nxt_rdata = save_valid ? save_data[63:32] : 32'h0000_0000;
         end else if (!(idx inside {[10'h198:10'h19D], perf_thermal_pkg::IDX_FEATURES,
                                    perf_thermal_pkg::IDX_EVT_STATUS,
                                    perf_thermal_pkg::IDX_EVT_MASK})) begin
            nxt_decerr = 1'b1;
         end
      end else begin
         case (idx)
            perf_thermal_pkg::IDX_CUR_PERF: nxt_rdata = {16'h0000, perf_s2_ff};
            perf_thermal_pkg::IDX_TGT_PERF: nxt_rdata = {16'h0000, tgt_perf_ff};
            perf_thermal_pkg::IDX_THROTTLE: nxt_rdata = {27'h0, thr_en_ff, thr_duty_ff, 1'b0};
            perf_thermal_pkg::IDX_THERM_IRQ: nxt_rdata = {30'h0, tirq_ff};
            perf_thermal_pkg::IDX_THERM_STATE: nxt_rdata = {30'h0, hot_log_ff, hot_s2_ff};
            perf_thermal_pkg::IDX_MON2_TGT: nxt_rdata = {16'h0000, mon2_ff};
            perf_thermal_pkg::IDX_FEATURES: nxt_rdata = {28'h0, fe_ff};
            perf_thermal_pkg::IDX_EVT_STATUS: nxt_rdata = {29'h0, evt_ff};
            perf_thermal_pkg::IDX_EVT_MASK: nxt_rdata = {29'h0, evt_mask_ff};
            default: begin
               if (idx >= perf_thermal_pkg::IDX_GPR_SAVE_BASE && idx < 10'h198) begin
                  nxt_rdata = save_valid ? save_data[31:0] : 32'h0000_0000;
               end else begin
                  nxt_decerr = 1'b1;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Avalon handshake: one wait cycle, answer, one idle cycle
   // ----------------------------------------
   logic [31:0] rdata_ff;
   logic [1:0] resp_ff;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= ST_IDLE;
         avs_waitrequest_o <= 1'b1;
         rdata_ff <= 32'h0000_0000;
         resp_ff <= 2'h0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (avs_read_i || avs_write_i) begin
                  state_ff <= ST_ANSWER;
                  avs_waitrequest_o <= 1'b0;
                  rdata_ff <= nxt_rdata;
                  resp_ff <= nxt_decerr ? 2'h3 : 2'h0;
               end
            end
            ST_ANSWER: begin
               state_ff <= ST_DONE;
               avs_waitrequest_o <= 1'b1;
            end
            ST_DONE: state_ff <= ST_IDLE;
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   assign avs_readdata_o = rdata_ff;
   assign avs_response_o = resp_ff;
   assign target_perf_o = tgt_perf_ff;
   assign throttle_en_o = thr_en_ff;
   assign throttle_duty_o = thr_duty_ff;
   // automatic modulation enable drives the core
   assign auto_mod_en_o = fe_ff[perf_thermal_pkg::FE_AUTO_MOD_BIT];
   assign fast_strings_en_o = fe_ff[perf_thermal_pkg::FE_FAST_STR_BIT];
   assign fop_compat_en_o = fe_ff[perf_thermal_pkg::FE_FOP_BIT];
   assign mon2_target_o = mon2_ff;
   assign gp_fault_o = gp_fault_ff;
   assign irq_o = irq_ff;

endmodule
`default_nettype wire

// *** hw/perf_thermal_pkg.sv ***
// Package: register offsets, field layouts and reset values of the perf/thermal bank
package perf_thermal_pkg;

   // ----------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------
   localparam logic [9:0] IDX_CUR_PERF = 10'h198;
   localparam logic [9:0] IDX_TGT_PERF = 10'h199;
   localparam logic [9:0] IDX_THROTTLE = 10'h19A;
   localparam logic [9:0] IDX_THERM_IRQ = 10'h19B;
   localparam logic [9:0] IDX_THERM_STATE = 10'h19C;
   localparam logic [9:0] IDX_MON2_TGT = 10'h19D;
   localparam logic [9:0] IDX_FEATURES = 10'h1A0;
   localparam logic [9:0] IDX_EVT_STATUS = 10'h1B0;
   localparam logic [9:0] IDX_EVT_MASK = 10'h1B1;
   localparam logic [9:0] IDX_GPR_SAVE_BASE = 10'h190;

   // ----------------------------------------
   // Field layouts
   // ----------------------------------------
   localparam int PERF_W = 16;
   localparam int THR_EN_BIT = 4;
   localparam int THR_DUTY_W = 3;
   localparam int TIRQ_HI_BIT = 0;
   localparam int TIRQ_LO_BIT = 1;
   localparam int TST_HOT_BIT = 0;
   localparam int TST_HOT_LOG_BIT = 1;
   localparam int MON2_W = 16;
   localparam int FE_FAST_STR_BIT = 0;
   localparam int FE_FOP_BIT = 2;
   localparam int FE_AUTO_MOD_BIT = 3;
   localparam int FE_W = 4;
   localparam int EVT_W = 3;
   localparam int EVT_HOT_BIT = 0;
   localparam int EVT_COOL_BIT = 1;
   localparam int EVT_GPF_BIT = 2;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [FE_W-1:0] FE_RESET = 4'h1;
   localparam logic [15:0] TGT_PERF_RESET = 16'h0000;
   localparam logic [15:0] MON2_RESET = 16'h0000;

   // Part model codes selecting second-monitor write behaviour
   localparam logic [3:0] MODEL_WRITES_OK = 4'h3;

endpackage

// *** tb/msr_bank_chk.sv ***
// Assertion checker bound to the perf/thermal register bank
`timescale 1ns/1ps
`default_nettype none
module msr_bank_chk #(
   parameter logic [3:0] PART_MODEL = 4'h3
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [13:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [1:0] avs_response_o,
   input wire logic [15:0] target_perf_o,
   input wire logic throttle_en_o,
   input wire logic [2:0] throttle_duty_o,
   input wire logic fast_strings_en_o,
   input wire logic fop_compat_en_o,
   input wire logic auto_mod_en_o,
   input wire logic [15:0] mon2_target_o,
   input wire logic gp_fault_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   logic ack;
   logic wr_full;
   logic [10:0] word;
   assign ack = !avs_waitrequest_o;
   assign word = avs_address_i[12:2];
   assign wr_full = avs_write_i && ack && avs_byteenable_i == 4'hF;
   // Full-word write landing on a low word; bus values come in as arguments so they are sampled
   function automatic logic wr_to(input logic en, input logic [10:0] w, input logic [9:0] idx);
      return en && w == {1'b0, idx};
   endfunction
   // ----------------------------------------
   // Bus timing
   // ----------------------------------------
   property p_one_wait;
      ack |=> !ack;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("answer held too long");
   property p_answer;
      (avs_read_i || avs_write_i) && !ack |-> ##[1:3] ack;
   endproperty
   a_answer: assert property (p_answer) else $error("request not answered");
   // ----------------------------------------
   // Register effects
   // ----------------------------------------
   property p_tgt;
      wr_to(wr_full, word, perf_thermal_pkg::IDX_TGT_PERF)
         |=> target_perf_o == $past(avs_writedata_i[15:0]);
   endproperty
   a_tgt: assert property (p_tgt) else $error("target not written");
   property p_tgt_hold;
      !avs_write_i |=> $stable(target_perf_o);
   endproperty
   a_tgt_hold: assert property (p_tgt_hold) else $error("target moved");
   property p_thr;
      wr_to(wr_full, word, perf_thermal_pkg::IDX_THROTTLE)
         |=> throttle_en_o == $past(avs_writedata_i[4])
         && throttle_duty_o == $past(avs_writedata_i[3:1]);
   endproperty
   a_thr: assert property (p_thr) else $error("throttle not written");
   property p_feat;
      wr_to(wr_full, word, perf_thermal_pkg::IDX_FEATURES)
         |=> fast_strings_en_o == $past(avs_writedata_i[0])
         && fop_compat_en_o == $past(avs_writedata_i[2])
         && auto_mod_en_o == $past(avs_writedata_i[3]);
   endproperty
   a_feat: assert property (p_feat) else $error("feature bits wrong");
   property p_mon2_ok;
      PART_MODEL == 4'h3 && wr_to(wr_full, word, perf_thermal_pkg::IDX_MON2_TGT)
         |=> mon2_target_o == $past(avs_writedata_i[15:0]);
   endproperty
   a_mon2_ok: assert property (p_mon2_ok) else $error("monitor target not set");
   property p_no_fault;
      PART_MODEL == 4'h3 |-> !gp_fault_o;
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("fault on model 3");
   property p_mon2_fault;
      PART_MODEL != 4'h3 && wr_to(wr_full, word, perf_thermal_pkg::IDX_MON2_TGT)
         |=> gp_fault_o && $stable(mon2_target_o) ##1 !gp_fault_o;
   endproperty
   a_mon2_fault: assert property (p_mon2_fault) else $error("faulting write wrong");
   property p_cur_rsv;
      avs_read_i && ack && word == {1'b0, perf_thermal_pkg::IDX_CUR_PERF}
         |-> avs_readdata_o[31:16] == 16'h0000;
   endproperty
   a_cur_rsv: assert property (p_cur_rsv) else $error("perf upper bits set");
   property p_hi_zero;
      avs_read_i && ack && word[10] && avs_response_o == 2'h0
         && word[9:3] != perf_thermal_pkg::IDX_GPR_SAVE_BASE[9:3] |-> avs_readdata_o == 32'h0;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("high word not zero");
endmodule
bind perf_thermal_msr_bank msr_bank_chk #(.PART_MODEL(PART_MODEL)) u_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
   .target_perf_o(target_perf_o), .throttle_en_o(throttle_en_o),
   .throttle_duty_o(throttle_duty_o), .fast_strings_en_o(fast_strings_en_o),
   .fop_compat_en_o(fop_compat_en_o), .auto_mod_en_o(auto_mod_en_o),
   .mon2_target_o(mon2_target_o), .gp_fault_o(gp_fault_o)
);
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the perf/thermal register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [9:0] TGT = perf_thermal_pkg::IDX_TGT_PERF;
   localparam logic [9:0] TIRQ = perf_thermal_pkg::IDX_THERM_IRQ;
   localparam logic [9:0] TST = perf_thermal_pkg::IDX_THERM_STATE;
   localparam logic [9:0] MON = perf_thermal_pkg::IDX_MON2_TGT;
   localparam logic [9:0] FEA = perf_thermal_pkg::IDX_FEATURES;
   localparam logic [9:0] EST = perf_thermal_pkg::IDX_EVT_STATUS;
   localparam logic [9:0] EMK = perf_thermal_pkg::IDX_EVT_MASK;
   localparam logic [9:0] GPR = perf_thermal_pkg::IDX_GPR_SAVE_BASE;
   logic clk_i, rst_n_i, rd, wr, wt, hot, cap, lm, irq, gpf2, gp_seen;
   logic thr_en, fast, fop, amod;
   logic [13:0] addr;
   logic [31:0] wdat, rdat, rdat2, got, g2, seed, d;
   logic [3:0] be;
   logic [1:0] resp, gresp;
   logic [15:0] cur, tgt, mon2, mon2_b;
   logic [2:0] duty;
   logic [511:0] gpr;
   int miscompares, num_checks, cycles;
   logic [9:0] idx_t [4] = '{TGT, perf_thermal_pkg::IDX_THROTTLE, TIRQ, FEA};
   logic [31:0] msk_t [4] = '{32'h0000FFFF, 32'h0000001E, 32'h00000003, 32'h0000000D};
   perf_thermal_msr_bank DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .avs_response_o(resp),
      .cur_perf_i(cur), .sensor_hot_i(hot), .mc_capture_i(cap), .long_mode_i(lm),
      .gpr_i(gpr), .target_perf_o(tgt), .throttle_en_o(thr_en), .throttle_duty_o(duty),
      .auto_mod_en_o(amod), .fast_strings_en_o(fast), .fop_compat_en_o(fop),
      .mon2_target_o(mon2), .gp_fault_o(), .irq_o(irq));
   // Faulting part model shares every input
   perf_thermal_msr_bank #(.PART_MODEL(4'h4)) DUT_M4 (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_byteenable_i(be), .avs_readdata_o(rdat2), .avs_waitrequest_o(),
      .avs_response_o(), .cur_perf_i(cur), .sensor_hot_i(hot), .mc_capture_i(cap),
      .long_mode_i(lm), .gpr_i(gpr), .target_perf_o(), .throttle_en_o(),
      .throttle_duty_o(), .auto_mod_en_o(), .fast_strings_en_o(), .fop_compat_en_o(),
      .mon2_target_o(mon2_b), .gp_fault_o(gpf2), .irq_o());
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Readback of a read/write register: only its implemented bits survive
   function automatic logic [31:0] expect_rw(input int k, input logic [31:0] v);
      return v & msk_t[k];
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Holds the request until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] dt,
                      input logic [3:0] b);
      addr <= {1'b0, a, 2'b00};
      rd <= !w;
      wr <= w;
      wdat <= dt;
      be <= b;
      do @(posedge clk_i); while (wt !== 1'b0);
      got = rdat;
      g2 = rdat2;
      gresp = resp;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rchk(input logic [10:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hF);
      chk(got, e);
   endtask
   always @(posedge clk_i) begin
      if (gpf2 === 1'b1) gp_seen <= 1'b1;
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         $display("mismatch at %0t: timeout", $time);
         complete_run();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst_n_i, rd, wr, hot, cap, lm, gp_seen} = 7'h00;
      {addr, wdat, be, cur, gpr} = '0;
      seed = 32'h00000049;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      chk({29'h0, amod, fop, fast}, 32'h00000001);
      rchk({1'b0, FEA}, 32'h00000001);
      rchk({1'b0, MON}, 32'h00000000);
      d = rnd();
      cur <= d[15:0];
      repeat (4) @(posedge clk_i);
      rchk({1'b0, perf_thermal_pkg::IDX_CUR_PERF}, {16'h0, d[15:0]});
      rchk({1'b1, perf_thermal_pkg::IDX_CUR_PERF}, 32'h0);
      $display("reset and status test done");
      for (int i = 0; i < 24; i++) begin
         d = rnd();
         bus(1'b1, {1'b0, idx_t[i % 4]}, d, 4'hF);
         bus(1'b1, {1'b1, idx_t[i % 4]}, ~d, 4'hF);
         rchk({1'b0, idx_t[i % 4]}, expect_rw(i % 4, d));
         rchk({1'b1, idx_t[i % 4]}, 32'h0);
      end
      bus(1'b1, {1'b0, TGT}, 32'h0000FFFF, 4'hF);
      bus(1'b1, {1'b0, TGT}, 32'h00000012, 4'h1);
      rchk({1'b0, TGT}, 32'h0000FF12);
      chk({16'h0, tgt}, 32'h0000FF12);
      bus(1'b1, {1'b0, idx_t[1]}, 32'h0000001A, 4'hF);
      chk({28'h0, thr_en, duty}, 32'h0000000D);
      bus(1'b1, {1'b0, FEA}, 32'h0000000E, 4'hF);
      rchk({1'b0, FEA}, 32'h0000000C);
      chk({29'h0, amod, fop, fast}, 32'h00000006);
      rchk(11'h3FF, 32'h0);
      chk({30'h0, gresp}, 32'h00000003);
      $display("read write test done");
      d = rnd();
      bus(1'b1, {1'b0, MON}, d, 4'hF);
      rchk({1'b0, MON}, {16'h0, d[15:0]});
      chk({16'h0, mon2}, {16'h0, d[15:0]});
      chk(g2, 32'h0);
      chk({15'h0, gp_seen, mon2_b}, 32'h00010000);
      rchk({1'b0, EST}, 32'h0);
      chk(g2, 32'h00000004);
      $display("monitor target test done");
      bus(1'b1, {1'b0, TIRQ}, 32'h0, 4'hF);
      hot <= 1'b1;
      repeat (6) @(posedge clk_i);
      rchk({1'b0, EST}, 32'h0);
      hot <= 1'b0;
      bus(1'b1, {1'b0, TST}, 32'h0, 4'hF);
      bus(1'b1, {1'b0, TIRQ}, 32'h00000003, 4'hF);
      bus(1'b1, {1'b0, EMK}, 32'h0, 4'hF);
      hot <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
      rchk({1'b0, EST}, 32'h00000001);
      rchk({1'b0, TST}, 32'h00000003);
      bus(1'b1, {1'b0, EMK}, 32'h00000007, 4'hF);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h00000001);
      bus(1'b1, {1'b0, EST}, 32'h00000001, 4'hF);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
      hot <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk({31'h0, irq}, 32'h00000001);
      rchk({1'b0, EST}, 32'h00000002);
      rchk({1'b0, TST}, 32'h00000002);
      bus(1'b1, {1'b0, TST}, 32'h0, 4'hF);
      rchk({1'b0, TST}, 32'h0);
      $display("thermal interrupt test done");
      for (int k = 0; k < 16; k++) gpr[32*k +: 32] <= rnd();
      lm <= 1'b1;
      cap <= 1'b1;
      @(posedge clk_i);
      cap <= 1'b0;
      repeat (2) @(posedge clk_i);
      for (int k = 0; k < 8; k++) begin
         rchk({1'b0, GPR + 10'(k)}, gpr[64*k +: 32]);
         rchk({1'b1, GPR + 10'(k)}, gpr[64*k+32 +: 32]);
      end
      lm <= 1'b0;
      cap <= 1'b1;
      @(posedge clk_i);
      cap <= 1'b0;
      repeat (2) @(posedge clk_i);
      rchk({1'b0, GPR + 10'h3}, 32'h0);
      $display("save area test done");
      complete_run();
   end
endmodule
`default_nettype wire
